// >>> logic/coproc_end.sv
// Coprocessor end: instruction tracking, busy, interrupt and bus handshake.
`timescale 1ns/1ps
module coproc_end (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	cop_link_if.cop         link,
	input  wire logic       busReq,
	output logic            busOwned,
	output logic            xferAck,
	input  wire logic       execDone,
	input  wire logic       excRaise,
	input  wire logic       excClear,
	input  wire logic       excMask,
	input  wire logic       intEnable,
	output logic            escStart,
	output logic [7:0]      escOpcode,
	output logic [7:0]      escModrm,
	output logic            modrmValid,
	output logic            operandRead,
	input  wire logic       auxBusRequestGrantIn,
	output logic            auxBusRequestGrantOut,
	output logic            auxBusRequestGrantOe_n
);

	////////////////////////////////////////////////////////////////////////
	// Reset synchroniser; the first stage feeds only the second.
	logic rstMeta_r;
	logic rstInt_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rstInt_r  <= 1'b0;
		end else begin
			rstMeta_r <= link.cpuReset;
			rstInt_r  <= rstMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction tracking and execution status.
	logic       run_r,        runNxt;
	logic       exc_r,        excNxt;
	logic       busy_r,       busyNxt;
	logic       int_r,        intNxt;
	logic       escStart_r,   escStartNxt;
	logic [7:0] opcode_r,     opcodeNxt;
	logic [7:0] modrm_r,      modrmNxt;
	logic       modrmVld_r,   modrmVldNxt;
	logic       wantModrm_r,  wantModrmNxt;
	logic       wantRead_r,   wantReadNxt;
	logic       opRead_r,     opReadNxt;
	logic [1:0] qs;
	logic       isEsc;

	assign qs    = {link.queueStatusHigh, link.queueStatusLow};
	assign isEsc = link.instrByte[cop_pkg::ESC_TOP:cop_pkg::ESC_BOT] ==
		cop_pkg::ESC_PREFIX;

	always_comb begin
		runNxt       = run_r;
		excNxt       = exc_r;
		escStartNxt  = 1'b0;
		opcodeNxt    = opcode_r;
		modrmNxt     = modrm_r;
		modrmVldNxt  = 1'b0;
		wantModrmNxt = wantModrm_r;
		wantReadNxt  = wantRead_r;
		opReadNxt    = 1'b0;
		if (execDone) begin
			runNxt = 1'b0;
		end
		case (qs)
			cop_pkg::QS_FIRST: begin
				opcodeNxt    = link.instrByte;
				wantModrmNxt = isEsc;
				if (isEsc) begin
					escStartNxt = 1'b1;
					runNxt      = 1'b1;
					wantReadNxt = 1'b0;
				end
			end
			cop_pkg::QS_NEXT: begin
				if (wantModrm_r) begin
					modrmNxt     = link.instrByte;
					modrmVldNxt  = 1'b1;
					wantModrmNxt = 1'b0;
					wantReadNxt  = link.instrByte[cop_pkg::MOD_TOP:
						cop_pkg::MOD_BOT] != cop_pkg::MOD_REG;
				end
			end
			cop_pkg::QS_FLUSH: begin
				wantModrmNxt = 1'b0;
			end
			default: begin
			end
		endcase
		// Only the first memory read after the escape carries the operand.
		if (wantRead_r && link.hostBusStatus == cop_pkg::BS_MEM_READ) begin
			opReadNxt   = 1'b1;
			wantReadNxt = 1'b0;
		end
		// A raise in the same cycle as a clear must not be lost.
		if (excClear) begin
			excNxt = 1'b0;
		end
		if (excRaise) begin
			excNxt = 1'b1;
		end
		busyNxt = runNxt | (excNxt & ~excMask);
		intNxt  = excNxt & intEnable & ~excMask;
		if (rstInt_r) begin
			runNxt       = 1'b0;
			excNxt       = 1'b0;
			busyNxt      = 1'b0;
			intNxt       = 1'b0;
			escStartNxt  = 1'b0;
			modrmVldNxt  = 1'b0;
			wantModrmNxt = 1'b0;
			wantReadNxt  = 1'b0;
			opReadNxt    = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r       <= 1'b0;
			exc_r       <= 1'b0;
			busy_r      <= 1'b0;
			int_r       <= 1'b0;
			escStart_r  <= 1'b0;
			opcode_r    <= 8'h00;
			modrm_r     <= 8'h00;
			modrmVld_r  <= 1'b0;
			wantModrm_r <= 1'b0;
			wantRead_r  <= 1'b0;
			opRead_r    <= 1'b0;
		end else begin
			run_r       <= runNxt;
			exc_r       <= excNxt;
			busy_r      <= busyNxt;
			int_r       <= intNxt;
			escStart_r  <= escStartNxt;
			opcode_r    <= opcodeNxt;
			modrm_r     <= modrmNxt;
			modrmVld_r  <= modrmVldNxt;
			wantModrm_r <= wantModrmNxt;
			wantRead_r  <= wantReadNxt;
			opRead_r    <= opReadNxt;
		end
	end

	assign link.busy   = busy_r;
	assign link.intReq = int_r;
	assign escStart    = escStart_r;
	assign escOpcode   = opcode_r;
	assign escModrm    = modrm_r;
	assign modrmValid  = modrmVld_r;
	assign operandRead = opRead_r;

	////////////////////////////////////////////////////////////////////////
	// Bus ownership and relay of the auxiliary request/grant line.
	cop_pkg::cop_bus_e bus_r, busNxt;
	logic hostOe_n_r,   hostOe_nNxt;
	logic auxOe_n_r,    auxOe_nNxt;
	logic dead_r,       deadNxt;
	logic auxOwn_r,     auxOwnNxt;
	logic relay_r,      relayNxt;
	logic relayGnt_r,   relayGntNxt;
	logic gntDly_r,     gntDlyNxt;
	logic owned_r,      ownedNxt;
	logic xferAck_r,    xferAckNxt;
	logic hostLow;
	logic auxLow;

	// Our own pulse also pulls the line low, so it is masked out here.
	assign hostLow = ~link.hostBusRequestGrant & hostOe_n_r;
	assign auxLow  = ~auxBusRequestGrantIn & auxOe_n_r;

	always_comb begin
		busNxt      = bus_r;
		hostOe_nNxt = 1'b1;
		auxOe_nNxt  = 1'b1;
		deadNxt     = 1'b0;
		auxOwnNxt   = auxOwn_r;
		relayNxt    = relay_r;
		relayGntNxt = relayGnt_r;
		gntDlyNxt   = 1'b0;
		case (bus_r)
			cop_pkg::BUS_IDLE: begin
				if (relay_r) begin
					if (!relayGnt_r && hostLow) begin
						relayGntNxt = 1'b1;
						gntDlyNxt   = 1'b1;
					end else if (relayGnt_r && auxLow) begin
						hostOe_nNxt = 1'b0;
						relayNxt    = 1'b0;
						relayGntNxt = 1'b0;
						deadNxt     = 1'b1;
					end
				end else if (auxLow && !dead_r) begin
					hostOe_nNxt = 1'b0;
					relayNxt    = 1'b1;
				end else if (busReq && !dead_r) begin
					hostOe_nNxt = 1'b0;
					busNxt      = cop_pkg::BUS_REQ;
				end
			end
			cop_pkg::BUS_REQ: begin
				if (hostLow) begin
					busNxt = cop_pkg::BUS_OWN;
				end
			end
			cop_pkg::BUS_OWN: begin
				if (auxOwn_r) begin
					if (auxLow) begin
						auxOwnNxt = 1'b0;
					end
				end else if (auxLow) begin
					auxOe_nNxt = 1'b0;
					auxOwnNxt  = 1'b1;
				end else if (!busReq) begin
					hostOe_nNxt = 1'b0;
					busNxt      = cop_pkg::BUS_REL;
				end
			end
			cop_pkg::BUS_REL: begin
				busNxt  = cop_pkg::BUS_IDLE;
				deadNxt = 1'b1;
			end
			default: begin
				busNxt = cop_pkg::BUS_IDLE;
			end
		endcase
		if (gntDly_r) begin
			auxOe_nNxt = 1'b0;
		end
		ownedNxt   = (busNxt == cop_pkg::BUS_OWN) & ~auxOwnNxt;
		xferAckNxt = owned_r & link.ready;
		if (rstInt_r) begin
			busNxt      = cop_pkg::BUS_IDLE;
			hostOe_nNxt = 1'b1;
			auxOe_nNxt  = 1'b1;
			deadNxt     = 1'b0;
			auxOwnNxt   = 1'b0;
			relayNxt    = 1'b0;
			relayGntNxt = 1'b0;
			gntDlyNxt   = 1'b0;
			ownedNxt    = 1'b0;
			xferAckNxt  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_r      <= cop_pkg::BUS_IDLE;
			hostOe_n_r <= 1'b1;
			auxOe_n_r  <= 1'b1;
			dead_r     <= 1'b0;
			auxOwn_r   <= 1'b0;
			relay_r    <= 1'b0;
			relayGnt_r <= 1'b0;
			gntDly_r   <= 1'b0;
			owned_r    <= 1'b0;
			xferAck_r  <= 1'b0;
		end else begin
			bus_r      <= busNxt;
			hostOe_n_r <= hostOe_nNxt;
			auxOe_n_r  <= auxOe_nNxt;
			dead_r     <= deadNxt;
			auxOwn_r   <= auxOwnNxt;
			relay_r    <= relayNxt;
			relayGnt_r <= relayGntNxt;
			gntDly_r   <= gntDlyNxt;
			owned_r    <= ownedNxt;
			xferAck_r  <= xferAckNxt;
		end
	end

	// Pulses are active low on an open-drain line, so the data is always 0.
	assign link.copRqOut          = 1'b0;
	assign link.copRqOe_n         = hostOe_n_r;
	assign auxBusRequestGrantOut  = 1'b0;
	assign auxBusRequestGrantOe_n = auxOe_n_r;
	assign busOwned               = owned_r;
	assign xferAck                = xferAck_r;

endmodule : coproc_end

// >>> logic/cop_pkg.sv
// Shared constants and state types for the coprocessor link.
package cop_pkg;

	////////////////////////////////////////////////////////////////////////
	// Queue status codes, high bit first.
	localparam logic [1:0] QS_NOP   = 2'h0;
	localparam logic [1:0] QS_FIRST = 2'h1;
	localparam logic [1:0] QS_FLUSH = 2'h2;
	localparam logic [1:0] QS_NEXT  = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Host bus status and instruction decode fields.
	localparam logic [2:0] BS_MEM_READ = 3'h5;
	localparam logic [4:0] ESC_PREFIX  = 5'h1b;
	localparam int         ESC_TOP     = 7;
	localparam int         ESC_BOT     = 3;
	localparam int         MOD_TOP     = 7;
	localparam int         MOD_BOT     = 6;
	localparam logic [1:0] MOD_REG     = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Reset must stand for at least this many clock cycles.
	localparam logic [2:0] RESET_HOLD_CYC = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Bus ownership states of the coprocessor end, Gray along the path.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_REQ  = 2'h1,
		BUS_OWN  = 2'h3,
		BUS_REL  = 2'h2
	} cop_bus_e;

	// Arbiter states of the host end, Gray along the coprocessor path.
	typedef enum logic [2:0] {
		ARB_IDLE  = 3'h0,
		ARB_GNT   = 3'h1,
		ARB_COP   = 3'h3,
		ARB_DEAD  = 3'h2,
		ARB_SPARE = 3'h6
	} arb_e;

endpackage : cop_pkg

// >>> logic/cop_link_if.sv
// Link between the host CPU end and the numeric coprocessor end.
`timescale 1ns/1ps
interface cop_link_if;

	logic       cpuReset;
	logic       ready;
	logic       busy;
	logic       intReq;
	logic [2:0] hostBusStatus;
	logic       queueStatusLow;
	logic       queueStatusHigh;
	logic [7:0] instrByte;
	logic       copRqOut;
	logic       copRqOe_n;
	logic       hostRqOut;
	logic       hostRqOe_n;
	logic       hostBusRequestGrant;

	////////////////////////////////////////////////////////////////////////
	// Open-drain line with pull-up: low while either end pulls it low.
	assign hostBusRequestGrant = ~((~copRqOe_n & ~copRqOut) |
		(~hostRqOe_n & ~hostRqOut));

	modport cop (
		input  cpuReset,
		input  ready,
		input  hostBusStatus,
		input  queueStatusLow,
		input  queueStatusHigh,
		input  instrByte,
		input  hostBusRequestGrant,
		output busy,
		output intReq,
		output copRqOut,
		output copRqOe_n
	);

	modport host (
		output cpuReset,
		output ready,
		output hostBusStatus,
		output queueStatusLow,
		output queueStatusHigh,
		output instrByte,
		input  hostBusRequestGrant,
		input  busy,
		input  intReq,
		output hostRqOut,
		output hostRqOe_n
	);

endinterface : cop_link_if

// >>> logic/host_end.sv
// Host end: reset source, queue status, wait on busy and bus arbiter.
`timescale 1ns/1ps
module host_end (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	cop_link_if.host        link,
	input  wire logic       rstReq,
	input  wire logic [1:0] qsIn,
	input  wire logic [7:0] byteIn,
	input  wire logic [2:0] busStatusIn,
	input  wire logic       memReady,
	input  wire logic       waitReq,
	output logic            waiting,
	output logic            waitDone,
	output logic            intSeen,
	input  wire logic       spareReq,
	input  wire logic       spareRel,
	output logic            spareGrant,
	output logic            hostOwnsBus
);

	////////////////////////////////////////////////////////////////////////
	// Reset pulse stretching, link drive and wait on busy.
	logic [2:0] rstCnt_r,   rstCntNxt;
	logic       rst_r,      rstNxt;
	logic       wait_r,     waitNxt;
	logic       done_r,     doneNxt;
	logic [1:0] qs_r;
	logic [7:0] byte_r;
	logic [2:0] bs_r;
	logic       rdy_r;
	logic       int_r;

	always_comb begin
		rstCntNxt = rstCnt_r;
		if (rstReq) begin
			rstCntNxt = cop_pkg::RESET_HOLD_CYC;
		end else if (rstCnt_r != 3'h0) begin
			rstCntNxt = rstCnt_r - 3'h1;
		end
		rstNxt  = rstCntNxt != 3'h0;
		waitNxt = wait_r;
		doneNxt = 1'b0;
		if (waitReq) begin
			waitNxt = 1'b1;
		end
		// Busy is sampled only while stalled; idle busy ends the wait.
		if (wait_r && !link.busy) begin
			waitNxt = 1'b0;
			doneNxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstCnt_r <= 3'h0;
			rst_r    <= 1'b0;
			wait_r   <= 1'b0;
			done_r   <= 1'b0;
			qs_r     <= cop_pkg::QS_NOP;
			byte_r   <= 8'h00;
			bs_r     <= 3'h7;
			rdy_r    <= 1'b0;
			int_r    <= 1'b0;
		end else begin
			rstCnt_r <= rstCntNxt;
			rst_r    <= rstNxt;
			wait_r   <= waitNxt;
			done_r   <= doneNxt;
			qs_r     <= qsIn;
			byte_r   <= byteIn;
			bs_r     <= busStatusIn;
			rdy_r    <= memReady;
			int_r    <= link.intReq;
		end
	end

	assign link.cpuReset        = rst_r;
	assign link.queueStatusHigh = qs_r[1];
	assign link.queueStatusLow  = qs_r[0];
	assign link.instrByte       = byte_r;
	assign link.hostBusStatus   = bs_r;
	assign link.ready           = rdy_r;
	assign waiting              = wait_r;
	assign waitDone             = done_r;
	assign intSeen              = int_r;

	////////////////////////////////////////////////////////////////////////
	// Arbiter: coprocessor line and spare line, first come first served.
	cop_pkg::arb_e arb_r, arbNxt;
	logic oe_n_r,   oe_nNxt;
	logic sGnt_r,   sGntNxt;
	logic own_r,    ownNxt;
	logic copLow;

	assign copLow = ~link.hostBusRequestGrant & oe_n_r;

	always_comb begin
		arbNxt  = arb_r;
		oe_nNxt = 1'b1;
		sGntNxt = 1'b0;
		case (arb_r)
			cop_pkg::ARB_IDLE: begin
				// On a tie the coprocessor line is taken; spare retries.
				if (copLow) begin
					oe_nNxt = 1'b0;
					arbNxt  = cop_pkg::ARB_GNT;
				end else if (spareReq) begin
					sGntNxt = 1'b1;
					arbNxt  = cop_pkg::ARB_SPARE;
				end
			end
			cop_pkg::ARB_GNT: begin
				arbNxt = cop_pkg::ARB_COP;
			end
			cop_pkg::ARB_COP: begin
				if (copLow) begin
					arbNxt = cop_pkg::ARB_DEAD;
				end
			end
			cop_pkg::ARB_SPARE: begin
				if (spareRel) begin
					arbNxt = cop_pkg::ARB_DEAD;
				end
			end
			cop_pkg::ARB_DEAD: begin
				arbNxt = cop_pkg::ARB_IDLE;
			end
			default: begin
				arbNxt = cop_pkg::ARB_IDLE;
			end
		endcase
		ownNxt = arbNxt == cop_pkg::ARB_IDLE;
		if (rst_r) begin
			arbNxt  = cop_pkg::ARB_IDLE;
			oe_nNxt = 1'b1;
			sGntNxt = 1'b0;
			ownNxt  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			arb_r  <= cop_pkg::ARB_IDLE;
			oe_n_r <= 1'b1;
			sGnt_r <= 1'b0;
			own_r  <= 1'b1;
		end else begin
			arb_r  <= arbNxt;
			oe_n_r <= oe_nNxt;
			sGnt_r <= sGntNxt;
			own_r  <= ownNxt;
		end
	end

	assign link.hostRqOut  = 1'b0;
	assign link.hostRqOe_n = oe_n_r;
	assign spareGrant      = sGnt_r;
	assign hostOwnsBus     = own_r;

endmodule : host_end

// >>> bench/cop_link_monitor.sv
// Concurrent checks on the signals of the coprocessor link.
`timescale 1ns/1ps
module cop_link_monitor (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       cpuReset,
	input wire logic       busy,
	input wire logic       intReq,
	input wire logic       queueStatusLow,
	input wire logic       queueStatusHigh,
	input wire logic [7:0] instrByte,
	input wire logic       copRqOe_n,
	input wire logic       hostRqOe_n,
	input wire logic       hostBusRequestGrant
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	// Pulses are counted modulo three per driver, not per line edge.
	// A grant that follows its request at once would merge into one
	// low stretch on the shared line and be missed.
	logic       copLast_r;
	logic       hostLast_r;
	logic [1:0] rstPipe_r;
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;
	logic       fallNow;
	logic       escNow;

	always_comb begin
		fallNow   = (copLast_r & ~copRqOe_n) | (hostLast_r & ~hostRqOe_n);
		// The coprocessor acts on reset two cycles late, so an escape
		// counts only once that delay is clear as well.
		escNow    = ({queueStatusHigh, queueStatusLow} == cop_pkg::QS_FIRST) &&
			(instrByte[7:3] == cop_pkg::ESC_PREFIX) && !cpuReset &&
			!rstPipe_r[1];
		phase_nxt = phase_r;
		if (fallNow)
			phase_nxt = (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			copLast_r  <= 1'b1;
			hostLast_r <= 1'b1;
			rstPipe_r  <= 2'h0;
			phase_r    <= 2'h0;
		end else begin
			copLast_r  <= copRqOe_n;
			hostLast_r <= hostRqOe_n;
			rstPipe_r  <= {rstPipe_r[0], cpuReset};
			phase_r    <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	reset_hold_a: assert property ($rose(cpuReset) |-> cpuReset[*4])
		else $error("link reset shorter than four cycles");
	reset_clear_a: assert property ($rose(cpuReset) |-> ##4 (!busy && !intReq))
		else $error("reset did not abandon work");
	esc_busy_a: assert property (escNow |=> busy)
		else $error("escape opcode did not raise busy");
	int_busy_a: assert property (intReq |-> busy)
		else $error("interrupt without busy");
	cop_pulse_a: assert property ($fell(copRqOe_n) |=> copRqOe_n)
		else $error("coprocessor pulse wider than one cycle");
	host_pulse_a: assert property ($fell(hostRqOe_n) |=> hostRqOe_n)
		else $error("host pulse wider than one cycle");
	grant_order_a: assert property (fallNow |-> hostRqOe_n == (phase_r != 2'h1))
		else $error("pulse out of request grant release order");
	dead_cycle_a: assert property ((fallNow && phase_r == 2'h2) |=> hostBusRequestGrant)
		else $error("no dead cycle after release");

	cover property (escNow ##1 busy);
	cover property (fallNow && phase_r == 2'h2);
	cover property ($rose(cpuReset));
	cover property (intReq);
endmodule : cop_link_monitor

// >>> bench/coprocessor_host_interface_test.sv
// Self-checking bench joining the host end and the coprocessor end.
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin check_count++; if ((act) !== (exp)) begin \
	error_cnt++; $display("CHECK FAILED at %0t: %s", $time, msg); end end
module coprocessor_host_interface_test;
	logic       sys_clk = 1'b0;
	logic       arst_n;
	logic       busReq, execDone, excRaise, excClear, excMask, intEnable;
	logic       rstReq, memReady, waitReq, spareReq, spareRel, auxPull;
	logic [1:0] qsIn;
	logic [7:0] byteIn, escOpcode, escModrm;
	logic [2:0] busStatusIn;
	logic       busOwned, xferAck, escStart, modrmValid, operandRead;
	logic       auxOut, auxOe_n, auxLine, waiting, waitDone, intSeen;
	logic       spareGrant, hostOwnsBus;
	int         cyc, escCnt, mvCnt, opCnt, ackCnt, wdCnt, sgCnt;
	int         tAux, tCop, tHg, tAg, error_cnt, check_count;

	// The aux line has a pull-up; the bench is the master on it.
	assign auxLine = ~((~auxOe_n & ~auxOut) | auxPull);
	always #5 sys_clk = ~sys_clk;

	cop_link_if link ();
	coproc_end coproc_end_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.link(link), .busReq(busReq), .busOwned(busOwned),
		.xferAck(xferAck), .execDone(execDone), .excRaise(excRaise),
		.excClear(excClear), .excMask(excMask), .intEnable(intEnable),
		.escStart(escStart), .escOpcode(escOpcode), .escModrm(escModrm),
		.modrmValid(modrmValid), .operandRead(operandRead),
		.auxBusRequestGrantIn(auxLine), .auxBusRequestGrantOut(auxOut),
		.auxBusRequestGrantOe_n(auxOe_n));
	host_end host_end_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.link(link), .rstReq(rstReq), .qsIn(qsIn), .byteIn(byteIn),
		.busStatusIn(busStatusIn), .memReady(memReady), .waitReq(waitReq),
		.waiting(waiting), .waitDone(waitDone), .intSeen(intSeen),
		.spareReq(spareReq), .spareRel(spareRel), .spareGrant(spareGrant),
		.hostOwnsBus(hostOwnsBus));
	cop_link_monitor cop_link_monitor_inst (.sys_clk(sys_clk),
		.arst_n(arst_n), .cpuReset(link.cpuReset), .busy(link.busy),
		.intReq(link.intReq), .queueStatusLow(link.queueStatusLow),
		.queueStatusHigh(link.queueStatusHigh),
		.instrByte(link.instrByte), .copRqOe_n(link.copRqOe_n),
		.hostRqOe_n(link.hostRqOe_n),
		.hostBusRequestGrant(link.hostBusRequestGrant));

	////////////////////////////////////////////////////////////////////////
	// Pulses are counted and line pulses time-stamped, so no check hangs
	// on catching a one-cycle output at the right moment.
	always @(posedge sys_clk) begin
		cyc++;
		escCnt += escStart;
		mvCnt += modrmValid;
		opCnt += operandRead;
		ackCnt += xferAck;
		wdCnt += waitDone;
		sgCnt += spareGrant;
		// Only the bench's own pulls count; the relayed grant also lowers
		// the aux line and must not move this stamp.
		if (auxPull) tAux = cyc;
		if (!link.copRqOe_n) tCop = cyc;
		if (!link.hostRqOe_n) tHg = cyc;
		if (!auxOe_n) tAg = cyc;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	task complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task feed(input logic [1:0] qs, input logic [7:0] b);
		qsIn = qs;
		byteIn = b;
		tick(1);
	endtask : feed

	task automatic wait_bit(const ref logic s, input logic v, input string m);
		for (int i = 0; i < 20 && s !== v; i++)
			tick(1);
		`CHK(s, v, m)
	endtask : wait_bit

	////////////////////////////////////////////////////////////////////////
	initial begin
		{busReq, execDone, excRaise, excClear, excMask, intEnable} = '0;
		{rstReq, memReady, waitReq, spareReq, spareRel, auxPull} = '0;
		{qsIn, byteIn, busStatusIn} = '0;
		arst_n = 1'b0;
		tick(10);
		arst_n = 1'b1;
		tick(2);
		feed(2'h1, 8'h90);
		feed(2'h3, 8'h06);
		feed(2'h1, 8'hd9);
		feed(2'h3, 8'h06);
		busStatusIn = cop_pkg::BS_MEM_READ;
		feed(2'h0, 8'h00);
		busStatusIn = 3'h0;
		feed(2'h1, 8'hdd);
		feed(2'h2, 8'h00);
		feed(2'h3, 8'h0e);
		feed(2'h0, 8'h00);
		tick(3);
		`CHK(escCnt, 2, "escape count")
		`CHK(mvCnt, 1, "modrm count")
		`CHK(opCnt, 1, "operand read count")
		`CHK({escOpcode, escModrm}, 16'hdd06, "captured bytes")
		`CHK(link.busy, 1'b1, "busy while running")
		pulse(execDone);
		tick(3);
		`CHK(link.busy, 1'b0, "busy after finish")
		intEnable = 1'b1;
		pulse(excRaise);
		tick(2);
		`CHK({link.busy, link.intReq, intSeen}, 3'h7, "exception")
		pulse(waitReq);
		tick(4);
		`CHK({waiting, wdCnt[0]}, 2'h2, "host stalls")
		pulse(excClear);
		tick(4);
		`CHK({link.intReq, wdCnt[0]}, 2'h1, "wait completes")
		excMask = 1'b1;
		pulse(excRaise);
		tick(3);
		`CHK({link.busy, link.intReq}, 2'h0, "masked exception")
		pulse(excClear);
		excMask = 1'b0;
		memReady = 1'b1;
		tick(3);
		memReady = 1'b0;
		busReq = 1'b1;
		wait_bit(busOwned, 1'b1, "bus taken");
		`CHK({ackCnt, hostOwnsBus}, {32'h0, 1'b0}, "idle ready")
		memReady = 1'b1;
		tick(3);
		memReady = 1'b0;
		tick(3);
		`CHK(ackCnt, 3, "ready acknowledges")
		pulse(auxPull);
		tick(3);
		`CHK({busOwned, tAg - tAux}, {1'b0, 32'h1}, "aux grant")
		pulse(auxPull);
		wait_bit(busOwned, 1'b1, "bus back");
		busReq = 1'b0;
		wait_bit(hostOwnsBus, 1'b1, "bus returned");
		tick(4);
		pulse(auxPull);
		tick(6);
		`CHK(tCop - tAux, 1, "request relayed")
		`CHK(tAg - tHg, 2, "grant relayed")
		pulse(auxPull);
		tick(2);
		`CHK(tCop - tAux, 1, "release relayed")
		tick(4);
		pulse(spareReq);
		tick(1);
		`CHK({sgCnt[0], hostOwnsBus}, 2'h2, "spare granted")
		pulse(spareRel);
		wait_bit(hostOwnsBus, 1'b1, "spare released");
		tick(4);
		feed(2'h1, 8'hd9);
		feed(2'h0, 8'h00);
		pulse(excRaise);
		pulse(rstReq);
		tick(8);
		`CHK({link.busy, link.intReq}, 2'h0, "reset abandons")
		complete_run();
	end
endmodule : coprocessor_host_interface_test
